// file: crce_pkg.sv
// Constants, register map and state codes of the programmable CRC engine
package crce_pkg;

    // ----------------------------------------
    // Register indices on the SFR port
    // ----------------------------------------
    localparam logic [2:0] REG_CONTROL_ONE       = 3'h0;
    localparam logic [2:0] REG_CONTROL_TWO       = 3'h1;
    localparam logic [2:0] REG_POLY_TAPS_LOW     = 3'h2;
    localparam logic [2:0] REG_POLY_TAPS_HIGH    = 3'h3;
    localparam logic [2:0] REG_INPUT_DATA_LOW    = 3'h4;
    localparam logic [2:0] REG_INPUT_DATA_HIGH   = 3'h5;
    localparam logic [2:0] REG_SHIFT_RESULT_LOW  = 3'h6;
    localparam logic [2:0] REG_SHIFT_RESULT_HIGH = 3'h7;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTL1_ENABLE_BIT    = 15;
    localparam int CTL1_IDLE_STOP_BIT = 13;
    localparam int CTL1_COUNT_LSB     = 8;
    localparam int CTL1_FULL_BIT      = 7;
    localparam int CTL1_EMPTY_BIT     = 6;
    localparam int CTL1_IRQ_SEL_BIT   = 5;
    localparam int CTL1_START_BIT     = 4;
    localparam int CTL1_ORDER_BIT     = 3;
    localparam int CTL2_WIDTH_LSB     = 8;
    localparam int CTL2_POLY_LENGTH_FIELD_LSB      = 0;
    localparam int FIELD_W            = 5;

    // ----------------------------------------
    // FIFO sizing and occupancy limits
    // ----------------------------------------
    localparam int         FIFO_WIDTH     = 32;
    localparam int         FIFO_DEPTH     = 32;
    localparam logic [4:0] CAP_BYTE       = 5'h10;
    localparam logic [4:0] CAP_HALF       = 5'h08;
    localparam logic [4:0] CAP_WORD       = 5'h04;
    localparam logic [4:0] WIDTH_BYTE_MAX = 5'h07;
    localparam logic [4:0] WIDTH_HALF_MAX = 5'h0F;
    localparam logic [4:0] LAST_BIT_POS   = 5'h1F;

    // ----------------------------------------
    // Reset values and all-ones mask
    // ----------------------------------------
    localparam logic [15:0] RST_HALF = 16'h0000;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_SPARE = 3'b100
    } crce_state_t;

endpackage

// file: crce_engine.sv
// Programmable serial CRC engine with its input FIFO and SFR port
// What this block does
// - Set tap bit XORs feedback at that position
// - Feedback position taken from length field
// - Constant term always fed; tap bit0 reads zero
// - Length 32 uses implicit top term
// - Standard 16 and 32 bit settings work
// - Data width 1 to 32, independent
// - Width up to 16 ignores high data
// - Data writes fill FIFO; reads give zero
// - Shift windows load and read engine
// - Bit order selects MSb or LSb first
// - Result never reflected
// - Taps, data, shift windows reset zero
// - Serial shifter, one bit per step
// - Disable clears engine, FIFO, data, shift
// - Shift only while started; starts once FIFO holds a word
// - FIFO holds 16, 8 or 4 words
// - Interrupt on completion or FIFO empty
`timescale 1ns/100ps

module crce_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  logic                       clk_sys,
    input  logic                       srst,
    input  logic                       flush,
    // Fill side
    input  logic                       in_valid,
    output logic                       in_ready,
    input  logic [WIDTH-1:0]           in_data,
    // Drain side
    output logic                       out_valid,
    input  logic                       out_ready,
    output logic [WIDTH-1:0]           out_data,
    // Occupancy
    output logic [$clog2(DEPTH):0]     count
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr_ptr;
        logic [PW-1:0]               rd_ptr;
        logic [PW:0]                 cnt;
    } crce_fifo_t;

    crce_fifo_t s_r;
    crce_fifo_t s_nxt;
    logic       do_wr;
    logic       do_rd;

    // Full compare at counter width; a pointer-width cast of the depth wraps to zero
    assign in_ready  = (s_r.cnt != (PW+1)'(DEPTH)) && !flush;
    assign out_valid = (s_r.cnt != '0) && !flush;
    assign out_data  = s_r.mem[s_r.rd_ptr];
    assign count     = s_r.cnt;

    always_comb begin
        s_nxt = s_r;
        do_wr = in_valid && in_ready;
        do_rd = out_valid && out_ready;
        if (do_wr) begin
            s_nxt.mem[s_r.wr_ptr] = in_data;
            s_nxt.wr_ptr          = s_r.wr_ptr + PW'(1);
        end
        if (do_rd) begin
            s_nxt.rd_ptr = s_r.rd_ptr + PW'(1);
        end
        s_nxt.cnt = s_r.cnt + (PW+1)'(do_wr) - (PW+1)'(do_rd);
        // Pointers only; stale words are never read back
        if (flush) begin
            s_nxt.wr_ptr = '0;
            s_nxt.rd_ptr = '0;
            s_nxt.cnt    = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

module crce_engine
    import crce_pkg::*;
(
    // Clock and reset
    input  logic        clk_sys,
    input  logic        srst,
    // Special function register port
    input  logic [2:0]  sfr_addr,
    input  logic        sfr_wr,
    input  logic [1:0]  sfr_be,
    input  logic [15:0] sfr_wdata,
    input  logic        sfr_rd,
    output logic [15:0] sfr_rdata,
    // Interrupt event
    output logic        crc_irq
);
    typedef struct packed {
        logic        enable;
        logic        idle_stop;
        logic        irq_select;
        logic        shift_start;
        logic        bit_order_select;
        logic [4:0]  data_width_field;
        logic [4:0]  poly_length_field;
        logic [31:0] taps;
        logic [15:0] data_hold;
        logic [31:0] shift_contents;
        logic [31:0] word_buf;
        logic [4:0]  bit_cnt;
        crce_state_t state;
        logic [15:0] rdata;
        logic        irq;
    } crce_regs_t;

    crce_regs_t  s_r;
    crce_regs_t  s_nxt;

    logic        push_valid;
    logic [31:0] push_data;
    logic        pop;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic [31:0] fifo_out_data;
    logic [5:0]  fifo_count;
    logic [4:0]  fifo_word_count;
    logic [4:0]  capacity;
    logic        fifo_full;
    logic        fifo_empty;
    logic [4:0]  bit_idx;
    logic        data_bit;
    logic        feedback;
    logic [31:0] step_sr;
    logic [31:0] len_mask;
    logic [15:0] rd_val;

    assign sfr_rdata = s_r.rdata;
    assign crc_irq   = s_r.irq;

    // ----------------------------------------
    // Input FIFO
    // ----------------------------------------
    crce_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .flush     (!s_r.enable),
        .in_valid  (push_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data),
        .out_valid (fifo_out_valid),
        .out_ready (pop),
        .out_data  (fifo_out_data),
        .count     (fifo_count)
    );

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] be);
        merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    endfunction

    always_comb begin
        s_nxt      = s_r;
        s_nxt.irq  = 1'b0;
        push_valid = 1'b0;
        push_data  = RST_WORD;
        pop        = 1'b0;
        rd_val     = RST_HALF;

        // ----------------------------------------
        // Occupancy and status
        // ----------------------------------------
        fifo_word_count = fifo_count[4:0];
        if (s_r.data_width_field <= WIDTH_BYTE_MAX) begin
            capacity = CAP_BYTE;
        end else if (s_r.data_width_field <= WIDTH_HALF_MAX) begin
            capacity = CAP_HALF;
        end else begin
            capacity = CAP_WORD;
        end
        fifo_full  = (fifo_word_count >= capacity);
        fifo_empty = (fifo_word_count == 5'h00);

        // ----------------------------------------
        // Serial step
        // ----------------------------------------
        // order of data only
        bit_idx  = s_r.bit_order_select ? (s_r.data_width_field - s_r.bit_cnt) : s_r.bit_cnt;
        data_bit = s_r.word_buf[bit_idx];
        feedback = data_bit ^ s_r.shift_contents[s_r.poly_length_field];
        step_sr[0] = feedback;
        for (int i = 1; i < 32; i++) begin
            step_sr[i] = s_r.shift_contents[i-1] ^ (s_r.taps[i] & feedback);
        end
        len_mask = ALL_ONES >> (LAST_BIT_POS - s_r.poly_length_field);

        // ----------------------------------------
        // Register reads
        // ----------------------------------------
        case (sfr_addr)
            REG_CONTROL_ONE: begin
                rd_val[CTL1_ENABLE_BIT]                       = s_r.enable;
                rd_val[CTL1_IDLE_STOP_BIT]                    = s_r.idle_stop;
                rd_val[CTL1_COUNT_LSB +: FIELD_W]             = fifo_word_count;
                rd_val[CTL1_FULL_BIT]                         = fifo_full;
                rd_val[CTL1_EMPTY_BIT]                        = fifo_empty;
                rd_val[CTL1_IRQ_SEL_BIT]                      = s_r.irq_select;
                rd_val[CTL1_START_BIT]                        = s_r.shift_start;
                rd_val[CTL1_ORDER_BIT]                        = s_r.bit_order_select;
            end
            REG_CONTROL_TWO: begin
                rd_val[CTL2_WIDTH_LSB +: FIELD_W] = s_r.data_width_field;
                rd_val[CTL2_POLY_LENGTH_FIELD_LSB +: FIELD_W]  = s_r.poly_length_field;
            end
            REG_POLY_TAPS_LOW:     rd_val = s_r.taps[15:0];
            REG_POLY_TAPS_HIGH:    rd_val = s_r.taps[31:16];
            REG_SHIFT_RESULT_LOW:  rd_val = s_r.shift_contents[15:0];
            REG_SHIFT_RESULT_HIGH: rd_val = s_r.shift_contents[31:16];
            default:               rd_val = RST_HALF;
        endcase
        if (sfr_rd) begin
            s_nxt.rdata = rd_val;
        end

        // ----------------------------------------
        // Register writes
        // ----------------------------------------
        if (sfr_wr) begin
            case (sfr_addr)
                REG_CONTROL_ONE: begin
                    if (sfr_be[1]) begin
                        s_nxt.enable    = sfr_wdata[CTL1_ENABLE_BIT];
                        s_nxt.idle_stop = sfr_wdata[CTL1_IDLE_STOP_BIT];
                    end
                    if (sfr_be[0]) begin
                        s_nxt.irq_select       = sfr_wdata[CTL1_IRQ_SEL_BIT];
                        s_nxt.shift_start      = sfr_wdata[CTL1_START_BIT];
                        s_nxt.bit_order_select = sfr_wdata[CTL1_ORDER_BIT];
                    end
                end
                REG_CONTROL_TWO: begin
                    // any width, set apart from length
                    if (sfr_be[1]) begin
                        s_nxt.data_width_field = sfr_wdata[CTL2_WIDTH_LSB +: FIELD_W];
                    end
                    if (sfr_be[0]) begin
                        s_nxt.poly_length_field = sfr_wdata[CTL2_POLY_LENGTH_FIELD_LSB +: FIELD_W];
                    end
                end
                REG_POLY_TAPS_LOW: begin
                    s_nxt.taps[15:0] = merge(s_r.taps[15:0], sfr_wdata, sfr_be) & 16'hFFFE;
                end
                REG_POLY_TAPS_HIGH: begin
                    s_nxt.taps[31:16] = merge(s_r.taps[31:16], sfr_wdata, sfr_be);
                end
                REG_INPUT_DATA_LOW: begin
                    if (s_r.data_width_field <= WIDTH_BYTE_MAX) begin
                        push_valid = |sfr_be;
                        push_data  = {24'h000000, sfr_be[0] ? sfr_wdata[7:0] : sfr_wdata[15:8]};
                    end else if (s_r.data_width_field <= WIDTH_HALF_MAX) begin
                        push_valid = 1'b1;
                        push_data  = {16'h0000, sfr_wdata};
                    end else begin
                        // low half waits for high half
                        s_nxt.data_hold = merge(s_r.data_hold, sfr_wdata, sfr_be);
                    end
                end
                REG_INPUT_DATA_HIGH: begin
                    if (s_r.data_width_field > WIDTH_HALF_MAX) begin
                        push_valid = 1'b1;
                        push_data  = {sfr_wdata, s_r.data_hold};
                    end
                end
                REG_SHIFT_RESULT_LOW: begin
                    s_nxt.shift_contents[15:0] = merge(s_r.shift_contents[15:0], sfr_wdata, sfr_be);
                end
                REG_SHIFT_RESULT_HIGH: begin
                    s_nxt.shift_contents[31:16] = merge(s_r.shift_contents[31:16], sfr_wdata, sfr_be);
                end
                default: begin
                end
            endcase
        end
        // Writes while full are dropped, as software is warned
        push_valid = push_valid && !fifo_full && s_r.enable;

        // ----------------------------------------
        // Shift sequencer
        // ----------------------------------------
        case (s_r.state)
            ST_IDLE: begin
                // needs start and a waiting word
                if (s_r.shift_start && fifo_out_valid) begin
                    pop            = 1'b1;
                    s_nxt.word_buf = fifo_out_data;
                    s_nxt.bit_cnt  = s_r.data_width_field;
                    s_nxt.state    = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (!s_r.shift_start) begin
                    // Abort keeps partial result, no interrupt
                    s_nxt.state = ST_IDLE;
                end else begin
                    s_nxt.shift_contents = step_sr & len_mask;
                    if (s_r.bit_cnt != 5'h00) begin
                        s_nxt.bit_cnt = s_r.bit_cnt - 5'h01;
                    end else if (fifo_out_valid) begin
                        pop            = 1'b1;
                        s_nxt.word_buf = fifo_out_data;
                        s_nxt.bit_cnt  = s_r.data_width_field;
                    end else begin
                        s_nxt.state       = ST_IDLE;
                        s_nxt.shift_start = 1'b0;
                        s_nxt.irq         = !s_r.irq_select;
                    end
                end
            end
            default: begin
                s_nxt.state = ST_IDLE;
            end
        endcase
        // count falls from one to zero
        if (s_r.irq_select && pop && fifo_word_count == 5'h01) begin
            s_nxt.irq = 1'b1;
        end

        // ----------------------------------------
        // Module disable
        // ----------------------------------------
        // configuration survives disable
        if (!s_r.enable) begin
            s_nxt.shift_start    = 1'b0;
            s_nxt.state          = ST_IDLE;
            s_nxt.data_hold      = RST_HALF;
            s_nxt.shift_contents = RST_WORD;
            s_nxt.word_buf       = RST_WORD;
            s_nxt.bit_cnt        = 5'h00;
            s_nxt.irq            = 1'b0;
            pop                  = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_r       <= '0;
            s_r.state <= ST_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// file: crce_engine_monitor.sv
// Assertion checker on the register port of the CRC engine
`timescale 1ns/100ps
module crce_engine_monitor
    import crce_pkg::*;
(
    // Clock and reset
    input logic        clk_sys,
    input logic        srst,
    // Register port
    input logic [2:0]  sfr_addr,
    input logic        sfr_wr,
    input logic [1:0]  sfr_be,
    input logic [15:0] sfr_wdata,
    input logic        sfr_rd,
    input logic [15:0] sfr_rdata,
    // Interrupt
    input logic        crc_irq
);
    logic       en_r;
    logic       go_r;
    logic [4:0] wid_r;
    logic [4:0] cap;

    // Start is also cleared by hardware; a stale high only skips checks
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            en_r  <= 1'b0;
            go_r  <= 1'b0;
            wid_r <= 5'h00;
        end else if (sfr_wr && sfr_addr == REG_CONTROL_ONE) begin
            if (sfr_be[1]) en_r <= sfr_wdata[CTL1_ENABLE_BIT];
            if (sfr_be[0]) go_r <= sfr_wdata[CTL1_START_BIT];
        end else if (sfr_wr && sfr_addr == REG_CONTROL_TWO && sfr_be[1]) begin
            wid_r <= sfr_wdata[12:8];
        end
    end
    assign cap = (wid_r <= WIDTH_BYTE_MAX) ? CAP_BYTE : (wid_r <= WIDTH_HALF_MAX) ? CAP_HALF : CAP_WORD;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_win_load;
        sfr_wr && sfr_addr == REG_SHIFT_RESULT_LOW && sfr_be == 2'b11 && en_r && !go_r
        ##1 !sfr_wr ##1 (sfr_rd && !sfr_wr && sfr_addr == REG_SHIFT_RESULT_LOW);
    endsequence
    sequence s_disable;
        sfr_wr && sfr_addr == REG_CONTROL_ONE && sfr_be[1] && !sfr_wdata[CTL1_ENABLE_BIT]
        ##1 !sfr_wr ##1 (sfr_rd && !sfr_wr);
    endsequence

    property p_rst;
        $fell(srst) |-> sfr_rdata == RST_HALF && !crc_irq;
    endproperty
    a_rst: assert property (p_rst) else $error("output not clear after reset");
    property p_irq;
        crc_irq |=> !crc_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt longer than one cycle");
    property p_dat;
        sfr_rd && (sfr_addr == REG_INPUT_DATA_LOW || sfr_addr == REG_INPUT_DATA_HIGH) |=> sfr_rdata == RST_HALF;
    endproperty
    a_dat: assert property (p_dat) else $error("data register read not zero");
    property p_tap0;
        sfr_rd && sfr_addr == REG_POLY_TAPS_LOW |=> !sfr_rdata[0];
    endproperty
    a_tap0: assert property (p_tap0) else $error("tap bit zero reads one");
    property p_cap;
        sfr_rd && sfr_addr == REG_CONTROL_ONE |=> sfr_rdata[12:8] <= cap
            && sfr_rdata[CTL1_FULL_BIT] == (sfr_rdata[12:8] == cap) && sfr_rdata[CTL1_EMPTY_BIT] == (sfr_rdata[12:8] == 5'h00);
    endproperty
    a_cap: assert property (p_cap) else $error("word count or flags wrong");
    property p_win;
        s_win_load |=> sfr_rdata == $past(sfr_wdata, 3);
    endproperty
    a_win: assert property (p_win) else $error("shift window not loaded");
    property p_dis_cnt;
        s_disable ##0 (sfr_addr == REG_CONTROL_ONE) |=> sfr_rdata[12:8] == 5'h00 && sfr_rdata[CTL1_EMPTY_BIT]
            && !sfr_rdata[CTL1_START_BIT];
    endproperty
    a_dis_cnt: assert property (p_dis_cnt) else $error("disable left fifo or start");
    property p_dis_win;
        s_disable ##0 (sfr_addr == REG_SHIFT_RESULT_LOW || sfr_addr == REG_SHIFT_RESULT_HIGH) |=> sfr_rdata == RST_HALF;
    endproperty
    a_dis_win: assert property (p_dis_win) else $error("disable left shift register");
endmodule

bind crce_engine crce_engine_monitor u_crce_engine_monitor (.clk_sys(clk_sys), .srst(srst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_be(sfr_be), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .crc_irq(crc_irq));

// file: crce_cpu_model.sv
// Processor model issuing register accesses to the CRC engine
`timescale 1ns/100ps
module crce_cpu_model
    import crce_pkg::*;
(
    // Clock
    input  logic        clk_sys,
    // Register port
    output logic [2:0]  sfr_addr,
    output logic        sfr_wr,
    output logic [1:0]  sfr_be,
    output logic [15:0] sfr_wdata,
    output logic        sfr_rd,
    input  logic [15:0] sfr_rdata
);
    initial begin
        sfr_addr  = REG_CONTROL_ONE;
        sfr_wr    = 1'b0;
        sfr_be    = 2'b00;
        sfr_wdata = RST_HALF;
        sfr_rd    = 1'b0;
    end
    task automatic wr(input logic [2:0] a, input logic [1:0] be, input logic [15:0] v);
        @(negedge clk_sys);
        sfr_addr  = a;
        sfr_be    = be;
        sfr_wdata = v;
        sfr_wr    = 1'b1;
        @(negedge clk_sys);
        sfr_wr    = 1'b0;
        // Idle bus shows inverted data, so stale data cannot pass
        sfr_wdata = ~v;
    endtask
    task automatic rd(input logic [2:0] a, output logic [15:0] v);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(negedge clk_sys);
        sfr_rd   = 1'b0;
        v        = sfr_rdata;
    endtask
    task automatic wr8(input logic [7:0] v);
        wr(REG_INPUT_DATA_LOW, 2'b01, {8'h00, v});
    endtask
    task automatic wr32(input logic [31:0] v);
        wr(REG_INPUT_DATA_LOW, 2'b11, v[15:0]);
        wr(REG_INPUT_DATA_HIGH, 2'b11, v[31:16]);
    endtask
endmodule

// file: crce_engine_tb.sv
// Self-checking bench of the programmable CRC engine
`timescale 1ns/100ps
module crce_engine_tb
    import crce_pkg::*;
;
    logic        clk_sys;
    logic        srst;
    logic [2:0]  sfr_addr;
    logic        sfr_wr;
    logic [1:0]  sfr_be;
    logic [15:0] sfr_wdata;
    logic        sfr_rd;
    logic [15:0] sfr_rdata;
    logic        crc_irq;
    logic [15:0] d;
    int          n_errors = 0;
    int          checks = 0;
    int          n_irq = 0;
    int          cycles = 0;

    crce_engine u_crce_engine (.clk_sys(clk_sys), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_be(sfr_be),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .crc_irq(crc_irq));
    crce_cpu_model u_crce_cpu_model (.clk_sys(clk_sys), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_be(sfr_be),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Generous ceiling: the whole run needs well under a thousand cycles
    // Falling edge, so the registered interrupt pulse is settled when counted
    always @(negedge clk_sys) begin
        cycles <= cycles + 1;
        if (crc_irq === 1'b1) n_irq <= n_irq + 1;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic w(input logic [2:0] a, input logic [15:0] v);
        u_crce_cpu_model.wr(a, 2'b11, v);
    endtask
    task automatic r(input logic [2:0] a);
        u_crce_cpu_model.rd(a, d);
    endtask
    task automatic push(input logic [4:0] wd, input logic [31:0] v);
        if (wd > WIDTH_HALF_MAX) u_crce_cpu_model.wr32(v);
        else if (wd > WIDTH_BYTE_MAX) w(REG_INPUT_DATA_LOW, v[15:0]);
        else u_crce_cpu_model.wr8(v[7:0]);
    endtask
    task automatic cfg(input logic [4:0] wd, input logic [4:0] ln, input logic [15:0] c1);
        w(REG_CONTROL_ONE, RST_HALF);
        w(REG_CONTROL_TWO, {3'h0, wd, 3'h0, ln});
        w(REG_CONTROL_ONE, c1);
    endtask
    function automatic logic [31:0] ref_word(logic [31:0] sr, logic [31:0] tp, logic [4:0] ln, logic [4:0] wd,
                                             logic lsb, logic [31:0] v);
        logic fb;
        for (int i = 0; i <= wd; i++) begin
            fb = (lsb ? v[i] : v[wd - i]) ^ sr[ln];
            // Tap bit 0 has no cell; the constant term always takes the feedback
            sr = (((sr << 1) ^ (tp & {32{fb}})) & (ALL_ONES >> (5'h1F - ln)) & ~32'h1) | {31'h0, fb};
        end
        return sr;
    endfunction
    task automatic run_crc(input logic [4:0] wd, input logic [4:0] ln, input logic [15:0] c1, input logic [31:0] tp,
                           input logic [31:0] init, input int n, input logic [31:0] dat [9], output logic [31:0] res);
        logic [31:0] exp;
        int          k;
        cfg(wd, ln, c1);
        w(REG_POLY_TAPS_LOW, tp[15:0]);
        w(REG_POLY_TAPS_HIGH, tp[31:16]);
        w(REG_SHIFT_RESULT_LOW, init[15:0]);
        w(REG_SHIFT_RESULT_HIGH, init[31:16]);
        exp = init;
        for (int i = 0; i < n; i++) begin
            push(wd, dat[i]);
            exp = ref_word(exp, tp, ln, wd, c1[CTL1_ORDER_BIT], dat[i]);
        end
        r(REG_CONTROL_ONE);
        chk({27'h0, d[12:8]}, n);
        r(REG_SHIFT_RESULT_LOW);
        chk({16'h0, d}, {16'h0, init[15:0]});
        k = n_irq;
        d = 16'hFFFF;
        w(REG_CONTROL_ONE, c1 | 16'h0010);
        for (int i = 0; i < 100 && d[CTL1_START_BIT] !== 1'b0; i++) r(REG_CONTROL_ONE);
        chk({31'h0, d[CTL1_START_BIT]}, 0);
        r(REG_SHIFT_RESULT_LOW);
        res[15:0] = d;
        r(REG_SHIFT_RESULT_HIGH);
        res[31:16] = d;
        chk(res, exp);
        chk(n_irq - k, 1);
    endtask

    task automatic t_reset();
        for (int a = 2; a < 8; a++) begin
            r(3'(a));
            chk({16'h0, d}, 0);
        end
        w(REG_POLY_TAPS_LOW, 16'hFFFF);
        r(REG_POLY_TAPS_LOW);
        chk({16'h0, d}, 32'h0000_FFFE);
        $display("test reset and taps done");
    endtask
    task automatic t_crc16();
        logic [31:0] res;
        run_crc(5'h07, 5'h0F, 16'h8000, 32'h0001_1020, 32'h0000_FFFF, 9,
                '{32'h31, 32'h32, 32'h33, 32'h34, 32'h35, 32'h36, 32'h37, 32'h38, 32'h39}, res);
        chk(res, 32'h0000_29B1);
        $display("test crc16 done");
    endtask
    task automatic t_wide();
        logic [31:0] res;
        run_crc(5'h1F, 5'h1F, 16'h8008, 32'h04C1_1DB6, ALL_ONES, 2,
                '{32'h3433_3231, 32'h3837_3635, 0, 0, 0, 0, 0, 0, 0}, res);
        run_crc(5'h13, 5'h09, 16'h8028, 32'h0000_0232, 32'h0000_0155, 2,
                '{32'hABC5_1234, 32'h0007_FFFF, 0, 0, 0, 0, 0, 0, 0}, res);
        run_crc(5'h04, 5'h06, 16'h8020, 32'h0000_0008, 32'h0000_0000, 3,
                '{32'hE5, 32'hFA, 32'h13, 0, 0, 0, 0, 0, 0}, res);
        $display("test widths and orders done");
    endtask
    task automatic t_high();
        cfg(5'h0F, 5'h0F, 16'h8000);
        w(REG_INPUT_DATA_HIGH, 16'h1234);
        r(REG_CONTROL_ONE);
        chk({27'h0, d[12:8]}, 0);
        cfg(5'h1F, 5'h1F, 16'h8000);
        w(REG_INPUT_DATA_LOW, 16'h1234);
        r(REG_INPUT_DATA_LOW);
        chk({16'h0, d}, 0);
        r(REG_CONTROL_ONE);
        chk({27'h0, d[12:8]}, 0);
        w(REG_INPUT_DATA_HIGH, 16'h5678);
        r(REG_CONTROL_ONE);
        chk({27'h0, d[12:8]}, 1);
        $display("test data halves done");
    endtask
    task automatic t_cap();
        logic [4:0] wd [3] = '{5'h07, 5'h0F, 5'h1F};
        logic [4:0] cp [3] = '{CAP_BYTE, CAP_HALF, CAP_WORD};
        for (int i = 0; i < 3; i++) begin
            cfg(wd[i], 5'h0F, 16'h8000);
            for (int j = 0; j <= cp[i]; j++) push(wd[i], 32'h0000_0055);
            r(REG_CONTROL_ONE);
            chk({26'h0, d[12:7]}, {26'h0, cp[i], 1'b1});
        end
        w(REG_POLY_TAPS_LOW, 16'h1020);
        w(REG_SHIFT_RESULT_LOW, 16'h5A5A);
        r(REG_SHIFT_RESULT_LOW);
        chk({16'h0, d}, 32'h0000_5A5A);
        w(REG_CONTROL_ONE, RST_HALF);
        r(REG_CONTROL_ONE);
        chk({26'h0, d[12:8], d[CTL1_EMPTY_BIT]}, 1);
        w(REG_CONTROL_ONE, RST_HALF);
        r(REG_SHIFT_RESULT_LOW);
        chk({16'h0, d}, 0);
        r(REG_POLY_TAPS_LOW);
        chk({16'h0, d}, 32'h0000_1020);
        $display("test capacity and disable done");
    endtask

    initial begin
        srst = 1'b1;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        srst = 1'b0;
        t_reset();
        t_crc16();
        t_wide();
        t_high();
        t_cap();
        end_of_test();
    end
endmodule
